// ==== sensor_ctrl_defines.vh ====
// constants for the offset, exposure and gain controller
// assumes inclusion by bare name from the design file
`ifndef SENSOR_CTRL_DEFINES_VH
`define SENSOR_CTRL_DEFINES_VH
// ------------------------------------------------------------------
// register offsets
// ------------------------------------------------------------------
`define ADDR_STATUS       8'h02
`define ADDR_FORMAT       8'h10
`define ADDR_MODE_SEL     8'h18
`define ADDR_FINE_HI      8'h20
`define ADDR_FINE_LO      8'h21
`define ADDR_COARSE_HI    8'h22
`define ADDR_COARSE_LO    8'h23
`define ADDR_GAIN         8'h24
`define ADDR_CLKDIV       8'h25
`define ADDR_DARK_EXT     8'h2a
`define ADDR_BLACK_EXT    8'h2b
`define ADDR_BLACK_SETUP  8'h2d
`define ADDR_DARK_SETUP   8'h2e
`define ADDR_LINE_HI      8'h52
`define ADDR_LINE_LO      8'h53
`define ADDR_FIELD_HI     8'h61
`define ADDR_FIELD_LO     8'h62
// ------------------------------------------------------------------
// field positions
// ------------------------------------------------------------------
`define CANCEL_MODE_LSB   0
`define CANCEL_HALF_BIT   2
`define CANCEL_WIDE_BIT   3
`define CANCEL_SHIFT_LSB  4
`define MODE_ADC9_BIT     0
`define MODE_IGAIN_BIT    1
`define FORMAT_24M_BIT    2
// ------------------------------------------------------------------
// encodings and reset values
// ------------------------------------------------------------------
`define FMT_VGA           2'h0
`define FMT_PAN_TILT_CIF_FORMAT         2'h1
`define FMT_PTQ           2'h2
`define FMT_SSQ           2'h3
`define OFS_NONE          2'h0
`define OFS_INTERNAL      2'h1
`define OFS_EXTERNAL      2'h2
`define DIV_HI_VGA        4'h0
`define DIV_HI_CIF        4'h1
`define DIV_HI_QVGA       4'h3
`define GAIN_RESET        8'hf8
`define IGAIN_MAX         4'he
`define CGAIN_PAD         2'h3
`define SETUP_RESET       8'h11
`define LINE_RESET        16'h0320
`define FIELD_RESET       16'h020d
`define BLACK_ACC_RESET   19'h70000
`define DARK_ACC_RESET    19'h00000
// ------------------------------------------------------------------
// algorithm and timing counts
// ------------------------------------------------------------------
`define BLACK_TARGET      12'h080
`define DARK_TARGET       12'h040
`define BAND_NARROW       12'h002
`define BAND_WIDE         12'h004
`define ERR_LIMIT         12'h07f
`define ACC_FRAC          10
`define AVG_SHIFT         10
`define FINE_OFS_VGA      16'h0031
`define FINE_OFS_PAN_TILT_CIF_FORMAT    16'h0035
`define FINE_OFS_QVGA     16'h006e
`endif

// ==== sensor_offset_exposure_gain_ctrl.v ====
// pixel fifo and offset / exposure / gain controller of the sensor core
// assumes serial-interface writes and the pixel stream share clk
`include "sensor_ctrl_defines.vh"

// ------------------------------------------------------------------
// pixel fifo
// ------------------------------------------------------------------
module pixel_fifo #(
  parameter WIDTH = 10,
  parameter DEPTH = 16,
  parameter AW    = 4
) (
  // clock and reset
  input  wire             clk,
  input  wire             nrst,
  input  wire             ce,
  // fill side
  input  wire             inValid,
  output wire             inReady,
  input  wire [WIDTH-1:0] inData,
  // drain side
  output wire             outValid,
  input  wire             outReady,
  output wire [WIDTH-1:0] outData
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW:0]      wrPtr_reg;
  reg [AW:0]      rdPtr_reg;
  wire            empty = (wrPtr_reg == rdPtr_reg);
  wire            full  = (wrPtr_reg[AW-1:0] == rdPtr_reg[AW-1:0]) &&
                          (wrPtr_reg[AW] != rdPtr_reg[AW]);

  assign inReady  = ~full;
  assign outValid = ~empty;
  assign outData  = mem[rdPtr_reg[AW-1:0]];

  always @(posedge clk) begin
    if (ce && inValid && !full)
      mem[wrPtr_reg[AW-1:0]] <= inData;
  end

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wrPtr_reg <= {(AW+1){1'b0}};
      rdPtr_reg <= {(AW+1){1'b0}};
    end else if (ce) begin
      if (inValid && !full)
        wrPtr_reg <= wrPtr_reg + 1'b1;
      if (outReady && !empty)
        rdPtr_reg <= rdPtr_reg + 1'b1;
    end
  end
endmodule

// ------------------------------------------------------------------
// controller top
// ------------------------------------------------------------------
module sensor_offset_exposure_gain_ctrl (
  // clock and reset
  input  wire        clk,
  input  wire        nrst,
  input  wire        ce,
  // serial register port
  input  wire        regWrEn,
  input  wire        regRdEn,
  input  wire [7:0]  regAddr,
  input  wire [7:0]  regWrData,
  output reg  [7:0]  regRdData,
  // raw pixel stream and line timing
  input  wire        pixValid,
  output wire        pixReady,
  input  wire [9:0]  pixData,
  input  wire [1:0]  lineKind,
  input  wire [3:0]  lineIdx,
  input  wire        savPulse,
  input  wire        firstDarkLine,
  input  wire        eofLine,
  input  wire        oddField,
  input  wire        fieldStart,
  input  wire        fieldEnd,
  input  wire        powerExit,
  // corrected pixel stream
  output wire        outValid,
  input  wire        outReady,
  output wire [9:0]  outData,
  // analogue and timing controls
  output reg  [3:0]  igain,
  output reg  [5:0]  cgain,
  output reg  [7:0]  sysClkDiv,
  output reg         extraDiv15,
  output reg  [15:0] coarseExp,
  output reg  [15:0] fineExp,
  output reg  [39:0] expInputClocks
);
  localparam KIND_BLACK = 2'h1;
  localparam KIND_DARK  = 2'h2;

  reg  [7:0]  format_reg, modeSel_reg, gain_reg, divLo_reg;
  reg  [7:0]  blackSetup_reg, darkSetup_reg, blackExt_reg, darkExt_reg;
  reg  [15:0] fineReq_reg, coarseReq_reg, lineLen_reg, fieldLen_reg;
  reg  [3:0]  divHi_reg;
  reg  [7:0]  gainStage_reg, gainWork_reg;
  reg         finePend_reg, coarsePend_reg, clkPend_reg, gainPend_reg;
  reg         gainStaged_reg;
  reg  [18:0] blackAcc_reg, darkAcc_reg;
  reg  [19:0] blackSum_reg, darkSum_reg;
  reg  [10:0] blackCnt_reg, darkCnt_reg;

  // ------------------------------------------------------------------
  // integrator with dead band and error limit
  // ------------------------------------------------------------------
  function [18:0] integ;
    input [18:0] acc;
    input [11:0] meas;
    input [11:0] target;
    input [2:0]  shf;
    input        wide;
    reg   [11:0] err;
    reg   [11:0] mag;
    reg   [18:0] step;
    begin
      err = target - meas;
      mag = err[11] ? (~err + 12'h001) : err;
      if (mag > `ERR_LIMIT)
        err = err[11] ? (~`ERR_LIMIT + 12'h001) : `ERR_LIMIT;
      step = $signed({{7{err[11]}}, err} <<< `ACC_FRAC) >>> shf;
      if (mag <= (wide ? `BAND_WIDE : `BAND_NARROW))
        integ = acc;
      else
        integ = acc + step;
    end
  endfunction

  // ------------------------------------------------------------------
  // offset selection and correction
  // ------------------------------------------------------------------
  wire [1:0]  blackMode = blackSetup_reg[`CANCEL_MODE_LSB+1:`CANCEL_MODE_LSB];
  wire [1:0]  darkMode  = darkSetup_reg[`CANCEL_MODE_LSB+1:`CANCEL_MODE_LSB];
  reg  [11:0] blackOfs, darkOfs;
  always @* begin
    case (blackMode)
      `OFS_INTERNAL: blackOfs = {{3{blackAcc_reg[18]}}, blackAcc_reg[18:10]};
      `OFS_EXTERNAL: blackOfs = {{4{blackExt_reg[7]}}, blackExt_reg};
      default:       blackOfs = 12'h000;
    endcase
    case (darkMode)
      `OFS_INTERNAL: darkOfs = {{3{darkAcc_reg[18]}}, darkAcc_reg[18:10]};
      `OFS_EXTERNAL: darkOfs = {{4{darkExt_reg[7]}}, darkExt_reg};
      default:       darkOfs = 12'h000;
    endcase
  end

  // clip so neither all-zeros nor all-ones leaves the block
  function [9:0] clip10;
    input [11:0] v;
    begin
      if (v[11] || v == 12'h000)
        clip10 = 10'h001;
      else if (v >= 12'h3ff)
        clip10 = 10'h3fe;
      else
        clip10 = v[9:0];
    end
  endfunction

  wire [11:0] blackCorr = {2'h0, pixData} + blackOfs;
  wire [9:0]  blackCorr10 = clip10(blackCorr);
  wire [9:0]  fullCorr10  = clip10({2'h0, blackCorr10} + darkOfs);
  wire        pixTake     = ce & pixValid & pixReady;

  pixel_fifo #(
    .WIDTH (10),
    .DEPTH (16),
    .AW    (4)
  ) u_fifo (
    .clk      (clk),
    .nrst     (nrst),
    .ce       (ce),
    .inValid  (pixValid),
    .inReady  (pixReady),
    .inData   (fullCorr10),
    .outValid (outValid),
    .outReady (outReady),
    .outData  (outData)
  );

  // ------------------------------------------------------------------
  // line selection and field averages
  // ------------------------------------------------------------------
  // only a fixed power-of-two count is summed, so no divider is needed
  wire blackSel = (lineKind == KIND_BLACK) &&
                  (lineIdx == 4'h1 || lineIdx == 4'h2);
  wire darkSel  = (lineKind == KIND_DARK) &&
                  (!darkSetup_reg[`CANCEL_HALF_BIT] || lineIdx[0]);
  wire [9:0]  blackAvg = blackSum_reg[19:10];
  wire [9:0]  darkAvg  = darkSum_reg[19:10];
  wire [11:0] blackMeas = {2'h0, blackAvg} + blackOfs;
  wire [11:0] darkSumC  = {2'h0, darkAvg} + darkOfs;
  wire [11:0] darkMeas  = {darkSumC[11], darkSumC[11:1]};
  wire        gainApply = ce & savPulse & eofLine & oddField & gainStaged_reg;
  wire        gainChange = gainApply && (gainStage_reg != gainWork_reg);

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      blackAcc_reg <= `BLACK_ACC_RESET;
      darkAcc_reg  <= `DARK_ACC_RESET;
      blackSum_reg <= 20'h00000;
      darkSum_reg  <= 20'h00000;
      blackCnt_reg <= 11'h000;
      darkCnt_reg  <= 11'h000;
    end else if (ce) begin
      if (fieldEnd) begin
        if (blackCnt_reg[`AVG_SHIFT])
          blackAcc_reg <= integ(blackAcc_reg, blackMeas, `BLACK_TARGET,
                                blackSetup_reg[6:4],
                                blackSetup_reg[`CANCEL_WIDE_BIT]);
        if (darkCnt_reg[`AVG_SHIFT])
          darkAcc_reg <= integ(darkAcc_reg, darkMeas, `DARK_TARGET,
                               darkSetup_reg[6:4],
                               darkSetup_reg[`CANCEL_WIDE_BIT]);
        blackSum_reg <= 20'h00000;
        darkSum_reg  <= 20'h00000;
        blackCnt_reg <= 11'h000;
        darkCnt_reg  <= 11'h000;
      end else if (pixTake) begin
        if (blackSel && !blackCnt_reg[`AVG_SHIFT]) begin
          blackSum_reg <= blackSum_reg + {10'h000, pixData};
          blackCnt_reg <= blackCnt_reg + 11'h001;
        end
        if (darkSel && !darkCnt_reg[`AVG_SHIFT]) begin
          darkSum_reg <= darkSum_reg + {10'h000, blackCorr10};
          darkCnt_reg <= darkCnt_reg + 11'h001;
        end
      end
      if (gainChange || powerExit)
        blackAcc_reg <= `BLACK_ACC_RESET;
    end
  end

  // ------------------------------------------------------------------
  // register writes and timed updates
  // ------------------------------------------------------------------
  wire wr = ce & regWrEn;
  reg  [3:0]  autoDivHi;
  reg  [15:0] fineOfs;
  always @* begin
    case (regWrData[1:0])
      `FMT_VGA:   autoDivHi = `DIV_HI_VGA;
      `FMT_PAN_TILT_CIF_FORMAT: autoDivHi = `DIV_HI_CIF;
      default:    autoDivHi = `DIV_HI_QVGA;
    endcase
    case (format_reg[1:0])
      `FMT_VGA:   fineOfs = `FINE_OFS_VGA;
      `FMT_PAN_TILT_CIF_FORMAT: fineOfs = `FINE_OFS_PAN_TILT_CIF_FORMAT;
      default:    fineOfs = `FINE_OFS_QVGA;
    endcase
  end

  wire [15:0] coarseMax = fieldLen_reg - 16'h0001;
  wire [15:0] fineMax   = lineLen_reg - fineOfs;
  wire        coarsePt  = ce & savPulse & firstDarkLine & oddField;
  wire        eofPt     = ce & savPulse & eofLine & oddField;
  wire        evenPt    = ce & fieldStart & !oddField;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      format_reg     <= 8'h00;
      modeSel_reg    <= 8'h00;
      gain_reg       <= `GAIN_RESET;
      divLo_reg      <= 8'h00;
      divHi_reg      <= `DIV_HI_VGA;
      blackSetup_reg <= `SETUP_RESET;
      darkSetup_reg  <= `SETUP_RESET;
      blackExt_reg   <= 8'h00;
      darkExt_reg    <= 8'h00;
      fineReq_reg    <= 16'h0000;
      coarseReq_reg  <= 16'h0000;
      lineLen_reg    <= `LINE_RESET;
      fieldLen_reg   <= `FIELD_RESET;
      finePend_reg   <= 1'b0;
      coarsePend_reg <= 1'b0;
      clkPend_reg    <= 1'b0;
      gainPend_reg   <= 1'b0;
      gainStaged_reg <= 1'b0;
      gainStage_reg  <= `GAIN_RESET;
      gainWork_reg   <= `GAIN_RESET;
      coarseExp      <= 16'h0000;
      fineExp        <= 16'h0000;
      sysClkDiv      <= 8'h00;
      extraDiv15     <= 1'b0;
    end else begin
      // a write in the cycle of an update keeps its pending flag set
      if (coarsePt && coarsePend_reg) begin
        coarseExp <= (coarseReq_reg > coarseMax) ? coarseMax
                                                 : coarseReq_reg;
        coarsePend_reg <= 1'b0;
      end
      if (eofPt && finePend_reg) begin
        fineExp <= (fineReq_reg > fineMax) ? fineMax : fineReq_reg;
        finePend_reg <= 1'b0;
      end
      if (eofPt) begin
        if (gainStaged_reg)
          gainWork_reg <= gainStage_reg;
        gainStaged_reg <= gainPend_reg;
        if (gainPend_reg)
          gainStage_reg <= gain_reg;
        gainPend_reg <= 1'b0;
      end
      if (evenPt && clkPend_reg) begin
        sysClkDiv  <= {divHi_reg, divLo_reg[3:0]};
        extraDiv15 <= (format_reg[1:0] == `FMT_PAN_TILT_CIF_FORMAT) &&
                      format_reg[`FORMAT_24M_BIT];
        clkPend_reg <= 1'b0;
      end
      if (wr) begin
        case (regAddr)
          `ADDR_FORMAT: begin
            format_reg  <= regWrData;
            divHi_reg   <= autoDivHi;
            clkPend_reg <= 1'b1;
          end
          `ADDR_MODE_SEL:    modeSel_reg <= regWrData;
          `ADDR_GAIN: begin
            gain_reg <= (regWrData[3:0] == 4'hf) ?
                        {regWrData[7:4], `IGAIN_MAX} : regWrData;
            gainPend_reg <= 1'b1;
          end
          `ADDR_CLKDIV: begin
            divLo_reg   <= {4'h0, regWrData[3:0]};
            clkPend_reg <= 1'b1;
          end
          `ADDR_BLACK_SETUP: blackSetup_reg <= regWrData;
          `ADDR_DARK_SETUP:  darkSetup_reg  <= regWrData;
          `ADDR_BLACK_EXT:   blackExt_reg   <= regWrData;
          `ADDR_DARK_EXT:    darkExt_reg    <= regWrData;
          `ADDR_FINE_HI: begin
            fineReq_reg[15:8] <= regWrData;
            finePend_reg      <= 1'b1;
          end
          `ADDR_FINE_LO: begin
            fineReq_reg[7:0] <= regWrData;
            finePend_reg     <= 1'b1;
          end
          `ADDR_COARSE_HI: begin
            coarseReq_reg[15:8] <= regWrData;
            coarsePend_reg      <= 1'b1;
          end
          `ADDR_COARSE_LO: begin
            coarseReq_reg[7:0] <= regWrData;
            coarsePend_reg     <= 1'b1;
          end
          `ADDR_LINE_HI:  lineLen_reg[15:8]  <= regWrData;
          `ADDR_LINE_LO:  lineLen_reg[7:0]   <= regWrData;
          `ADDR_FIELD_HI: fieldLen_reg[15:8] <= regWrData;
          `ADDR_FIELD_LO: fieldLen_reg[7:0]  <= regWrData;
          default: ;
        endcase
      end
    end
  end

  // ------------------------------------------------------------------
  // gain codes, exposure figure and readback
  // ------------------------------------------------------------------
  // total input-clock divide: basic (2, 4 or 8, 6 with 1.5) times optional
  reg  [3:0] basicDiv;
  wire [3:0] optDiv = (sysClkDiv[3:0] == 4'h0) ? 4'h1 : sysClkDiv[3:0];
  always @* begin
    case (sysClkDiv[7:4])
      `DIV_HI_VGA: basicDiv = 4'h2;
      `DIV_HI_CIF: basicDiv = extraDiv15 ? 4'h6 : 4'h4;
      default:     basicDiv = 4'h8;
    endcase
  end
  wire [31:0] lineProd = coarseExp * lineLen_reg;
  wire [32:0] pixClks  = {1'b0, lineProd} + {17'h00000, fineExp};
  wire [7:0]  totDiv   = basicDiv * optDiv;
  wire [40:0] expProd  = pixClks * totDiv;

  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      igain          <= 4'h0;
      cgain          <= 6'h00;
      expInputClocks <= 40'h0000000000;
      regRdData      <= 8'h00;
    end else if (ce) begin
      if (modeSel_reg[`MODE_IGAIN_BIT])
        igain <= ~gainWork_reg[3:0];
      else
        igain <= ~{gainWork_reg[0], gainWork_reg[1],
                   gainWork_reg[2], gainWork_reg[3]};
      if (modeSel_reg[`MODE_ADC9_BIT])
        cgain <= {1'b0, gainWork_reg[7:5], `CGAIN_PAD};
      else
        cgain <= {gainWork_reg[7:4], `CGAIN_PAD};
      expInputClocks <= expProd[39:0];
      if (regRdEn) begin
        case (regAddr)
          `ADDR_STATUS:      regRdData <= {4'h0, gainPend_reg, clkPend_reg,
                                           coarsePend_reg, finePend_reg};
          `ADDR_FORMAT:      regRdData <= format_reg;
          `ADDR_MODE_SEL:    regRdData <= modeSel_reg;
          `ADDR_GAIN:        regRdData <= gain_reg;
          `ADDR_CLKDIV:      regRdData <= {divHi_reg, divLo_reg[3:0]};
          `ADDR_BLACK_SETUP: regRdData <= blackSetup_reg;
          `ADDR_DARK_SETUP:  regRdData <= darkSetup_reg;
          `ADDR_BLACK_EXT:   regRdData <= blackExt_reg;
          `ADDR_DARK_EXT:    regRdData <= darkExt_reg;
          `ADDR_FINE_HI:     regRdData <= fineReq_reg[15:8];
          `ADDR_FINE_LO:     regRdData <= fineReq_reg[7:0];
          `ADDR_COARSE_HI:   regRdData <= coarseReq_reg[15:8];
          `ADDR_COARSE_LO:   regRdData <= coarseReq_reg[7:0];
          `ADDR_LINE_HI:     regRdData <= lineLen_reg[15:8];
          `ADDR_LINE_LO:     regRdData <= lineLen_reg[7:0];
          `ADDR_FIELD_HI:    regRdData <= fieldLen_reg[15:8];
          `ADDR_FIELD_LO:    regRdData <= fieldLen_reg[7:0];
          default:           regRdData <= 8'h00;
        endcase
      end
    end
  end
endmodule

// ==== sensor_ctrl_props.sv ====
// checker: port relations of the offset, exposure and gain controller
// assumes bind onto the controller top; field length left at reset
module sensor_ctrl_props (
  // clock and reset
  input logic        clk,
  input logic        nrst,
  input logic        ce,
  // register port
  input logic        regWrEn,
  input logic        regRdEn,
  input logic [7:0]  regAddr,
  input logic [7:0]  regWrData,
  input logic [7:0]  regRdData,
  // timing points
  input logic        savPulse,
  input logic        firstDarkLine,
  input logic        eofLine,
  input logic        oddField,
  input logic        fieldStart,
  // outputs watched
  input logic [5:0]  cgain,
  input logic [7:0]  sysClkDiv,
  input logic [15:0] coarseExp,
  input logic [15:0] fineExp,
  input logic        outValid,
  input logic [9:0]  outData
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  sequence sWr(a);
    ce && regWrEn && regAddr == a;
  endsequence
  sequence sRd(a);
    ce && regRdEn && !regWrEn && regAddr == a;
  endsequence

  a_cgain_pad: assert property (
    $past(nrst) |-> cgain[1:0] == 2'b11) else $error("cgain pad wrong");
  a_div_lowonly: assert property (
    sWr(8'h25) ##2 sRd(8'h25) |=> regRdData[3:0] == $past(regWrData[3:0], 3))
    else $error("divisor low nibble lost");
  a_gain_clip: assert property (
    sWr(8'h24) ##2 sRd(8'h24) |=> regRdData[3:0] != 4'hf &&
      regRdData[7:4] == $past(regWrData[7:4], 3)) else $error("gain stored wrong");
  a_coarse_point: assert property (
    $past(nrst, 2) && !$stable(coarseExp) |->
      $past(ce && savPulse && firstDarkLine && oddField))
    else $error("coarse moved off point");
  a_coarse_max: assert property (
    coarseExp <= 16'h020c) else $error("coarse over field length");
  a_fine_point: assert property (
    $past(nrst, 2) && !$stable(fineExp) |->
      $past(ce && savPulse && eofLine && oddField))
    else $error("fine moved off point");
  a_div_point: assert property (
    $past(nrst, 2) && !$stable(sysClkDiv) |-> $past(ce && fieldStart && !oddField))
    else $error("divisor moved off point");
  a_pix_range: assert property (
    outValid |-> outData inside {[10'h001:10'h3fe]}) else $error("pixel unclipped");
endmodule

// ==== pix_sink.sv ====
// partner: corrected-pixel consumer of the video coprocessor
// assumes outputs of the controller settle before the next edge
module pix_sink (
  // clock and control
  input  logic       clk,
  input  logic       nrst,
  input  logic       stall,
  // stream
  input  logic       outValid,
  input  logic [9:0] outData,
  output logic       outReady
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [9:0] got[$];
  initial outReady = 1'b0;
  // random ready gives both prompt and slow acceptance
  always @(posedge clk) begin
    if (nrst && outValid && outReady) got.push_back(outData);
    #1 outReady = !stall && $urandom_range(1, 0);
  end
endmodule

// ==== tb_sensor_offset_exposure_gain_ctrl.sv ====
// testbench: registers, timed updates and pixel path of the controller
// assumes 125 MHz clk, field and line lengths left at reset
module tb_sensor_offset_exposure_gain_ctrl;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 0, nrst = 0, ce = 1, regWrEn = 0, regRdEn = 0, pixValid = 0;
  logic savPulse = 0, firstDarkLine = 0, eofLine = 0, oddField = 0;
  logic fieldStart = 0, fieldEnd = 0, powerExit = 0, stall = 0;
  logic [7:0] regAddr = 0, regWrData = 0, regRdData, sysClkDiv;
  logic [9:0] pixData = 0, outData, expq[$];
  logic [1:0] lineKind = 0;
  logic [3:0] lineIdx = 0, igain;
  logic [5:0] cgain;
  logic extraDiv15, pixReady, outValid, outReady;
  logic [15:0] coarseExp, fineExp;
  logic [39:0] expInputClocks;
  int bad_count = 0, n_checks = 0, cyc = 0;

  sensor_offset_exposure_gain_ctrl u_dut (.clk, .nrst, .ce, .regWrEn,
    .regRdEn, .regAddr, .regWrData, .regRdData, .pixValid, .pixReady,
    .pixData, .lineKind, .lineIdx, .savPulse, .firstDarkLine, .eofLine,
    .oddField, .fieldStart, .fieldEnd, .powerExit, .outValid, .outReady,
    .outData, .igain, .cgain, .sysClkDiv, .extraDiv15, .coarseExp, .fineExp,
    .expInputClocks);
  pix_sink u_sink (.clk, .nrst, .stall, .outValid, .outData, .outReady);

  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc++;
    if (cyc == 30000) begin
      bad_count++;
      end_sim;
    end
  end
  // ------------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------------
  task end_sim;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task chk(input logic [39:0] got, input logic [39:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  // one idle cycle between accesses keeps each strobe a clean pulse
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1 regAddr = a;
    regWrData = d;
    regWrEn = 1;
    @(posedge clk);
    #1 regWrEn = 0;
  endtask
  task rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1 regAddr = a;
    regRdEn = 1;
    @(posedge clk);
    #1 regRdEn = 0;
    @(posedge clk);
    #1 d = regRdData;
  endtask
  task pt(input logic s, input logic f, input logic e, input logic o,
          input logic fs);
    @(posedge clk);
    #1 {savPulse, firstDarkLine, eofLine, oddField, fieldStart} = {s, f, e, o, fs};
    @(posedge clk);
    #1 {savPulse, fieldStart} = 2'b00;
  endtask
  function logic [9:0] clip(input logic [9:0] p, input int o);
    int v;
    v = int'(p) + o;
    return (v < 1) ? 10'h001 : (v > 1022) ? 10'h3fe : 10'(v);
  endfunction
  task push(input logic [9:0] p);
    pixData = p;
    pixValid = 1;
    while (pixReady !== 1'b1) begin
      @(posedge clk);
      #1;
    end
    @(posedge clk);
    #1;
  endtask
  task burst(input int n, input int ofs);
    logic [9:0] p;
    for (int i = 0; i < n; i++) begin
      p = (i == 0) ? 10'h000 : (i == 1) ? 10'h3ff : 10'($urandom);
      expq.push_back(clip(p, ofs));
      push(p);
    end
    pixValid = 0;
  endtask
  // selected lines carry p, the rest a far value that would pull the
  // average away if it were wrongly summed
  task field(input logic [1:0] kind, input logic [9:0] p);
    lineKind = kind;
    for (int i = 0; i < 2048; i++) begin
      lineIdx = 4'(i % 4);
      push(((kind == 2'h1) ? (lineIdx == 1 || lineIdx == 2) : lineIdx[0]) ?
           p : 10'h3f0);
    end
    pixValid = 0;
    lineKind = 2'h0;
    fieldEnd = 1;
    @(posedge clk);
    #1 fieldEnd = 0;
    while (outValid) begin
      @(posedge clk);
      #1;
    end
    u_sink.got.delete();
  endtask
  task drain;
    while (u_sink.got.size() < expq.size()) @(posedge clk);
    #1;
    foreach (expq[i]) chk(u_sink.got[i], expq[i]);
    expq.delete();
    u_sink.got.delete();
  endtask
  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    logic [7:0] d, g, lo;
    logic [3:0] hi;
    logic [15:0] fe;
    void'($urandom(30580));
    repeat (4) @(posedge clk);
    #1 nrst = 1;
    rd(8'h24, d);
    chk(d, 8'hf8);
    rd(8'h2e, d);
    chk(d, 8'h11);
    rd(8'h7f, d);
    chk(d, 0);
    for (int m = 0; m < 4; m++) begin
      g = {(m == 1) ? 4'($urandom) : 4'hf, 4'($urandom_range(14, 0))};
      wr(8'h18, 8'(m));
      pt(0, 0, 0, 0, 1);
      wr(8'h24, g);
      pt(1, 0, 1, 1, 0);
      pt(1, 0, 1, 1, 0);
      repeat (3) @(posedge clk);
      #1 chk(igain, m[1] ? {~g[3:0]} : {~{g[0], g[1], g[2], g[3]}});
      chk(cgain, m[0] ? {1'b0, g[7:5], 2'b11} : {g[7:4], 2'b11});
    end
    wr(8'h24, 8'hff);
    rd(8'h24, d);
    chk(d, 8'hfe);
    // clock enable low: a write must not land
    ce = 0;
    wr(8'h24, 8'h12);
    ce = 1;
    rd(8'h24, d);
    chk(d, 8'hfe);
    for (int k = 0; k < 2; k++) begin
      fe = k ? 16'h0100 : 16'hffff;
      wr(8'h22, fe[15:8]);
      wr(8'h23, fe[7:0]);
      pt(1, 1, 0, 1, 0);
      repeat (2) @(posedge clk);
      #1 chk(coarseExp, k ? fe : 16'h020c);
    end
    for (int f = 0; f < 4; f++) begin
      hi = (f == 0) ? 4'h0 : (f == 1) ? 4'h1 : 4'h3;
      fe = 16'h0320 - ((f == 0) ? 16'd49 : (f == 1) ? 16'd53 : 16'd110);
      lo = 8'($urandom);
      wr(8'h10, (f == 1) ? 8'h05 : 8'(f));
      wr(8'h25, lo);
      rd(8'h25, d);
      chk(d, {hi, lo[3:0]});
      wr(8'h20, 8'hff);
      wr(8'h21, 8'hff);
      pt(0, 0, 0, 0, 1);
      pt(1, 0, 1, 1, 0);
      repeat (3) @(posedge clk);
      #1 chk(sysClkDiv, {hi, lo[3:0]});
      chk(fineExp, fe);
      chk(extraDiv15, f == 1);
      chk(expInputClocks, (40'h100 * 40'h320 + fe)
          * ((f == 0) ? 40'h2 : (f == 1) ? 40'h6 : 40'h8)
          * ((lo[3:0] == 0) ? 40'h1 : 40'(lo[3:0])));
    end
    for (int m = 0; m < 3; m++) begin
      wr(8'h2d, 8'(m));
      wr(8'h2b, 8'hfb);
      pt(0, 0, 0, 0, 1);
      burst(12, (m == 1) ? -64 : (m == 2) ? -5 : 0);
      drain;
    end
    // far side stalled: sixteen words fill the buffer
    stall = 1;
    repeat (2) @(posedge clk);
    #1 burst(16, -5);
    chk(pixReady, 1'b0);
    stall = 0;
    drain;
    // black integrator: one step of -8, then a field inside the band
    wr(8'h2d, 8'h01);
    field(2'h1, 10'h0c8);
    burst(4, -72);
    drain;
    field(2'h1, 10'h0c6);
    burst(4, -72);
    drain;
    powerExit = 1;
    @(posedge clk);
    #1 powerExit = 0;
    burst(4, -64);
    drain;
    // dark on half lines: black-corrected 136 halves to 68, a step of -4
    wr(8'h2e, 8'h05);
    field(2'h2, 10'h0c8);
    burst(4, -68);
    drain;
    end_sim;
  end
endmodule

bind sensor_offset_exposure_gain_ctrl sensor_ctrl_props u_props (.clk, .nrst,
  .ce, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData, .savPulse,
  .firstDarkLine, .eofLine, .oddField, .fieldStart, .cgain, .sysClkDiv,
  .coarseExp, .fineExp, .outValid, .outData);
